// ---- rtl/ttc_defines.vh ----
// Constants for the trace trigger and capture block
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH

// Widths
`define TTC_AW          12
`define TTC_TPW         10
`define TTC_RAW         8
`define TTC_REGAW       4

// Register offsets
`define TTC_REG_MODE    4'h0
`define TTC_REG_START   4'h1
`define TTC_REG_START_HI 4'h2
`define TTC_REG_STOP    4'h3
`define TTC_REG_STOP_HI 4'h4
`define TTC_REG_MATCH   4'h5
`define TTC_REG_RAMADR  4'h6
`define TTC_REG_OBJSEL  4'h7
`define TTC_REG_TPTR    4'h8
`define TTC_REG_ENBIT   4'h9
`define TTC_REG_ENADR   4'hA
`define TTC_REG_STATUS  4'hB

// Capture modes
`define TTC_M_FREE      3'h0
`define TTC_M_ENBIT     3'h1
`define TTC_M_OFF       3'h2
`define TTC_M_WINDOW    3'h3
`define TTC_M_AFTER     3'h4
`define TTC_M_BEFORE    3'h5

// Start/stop kind codes
`define TTC_K_KEEP      2'h0
`define TTC_K_ADDR      2'h1
`define TTC_K_RANGE     2'h2
`define TTC_K_RUN       2'h3

// Mode register fields
`define TTC_MODE_LSB    0
`define TTC_SRC_BIT     4
`define TTC_RAMSEL_BIT  5

// Match register fields: value [7:0], mask [15:8]
`define TTC_MVAL_LSB    0
`define TTC_MMSK_LSB    8

// Reset value and match source compare masks
`define TTC_MODE_RST    3'h0
`define TTC_RAM_MASK    8'h0F
`define TTC_PRB_MASK    8'hFF

`endif

// ---- rtl/ttc_trace_trigger.v ----
// Trace trigger and capture logic of the emulator trace unit
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "ttc_defines.vh"

module ttc_trace_trigger (
	input  wire                   mclk,
	input  wire                   rst_n,
	input  wire [`TTC_REGAW-1:0]  reg_addr,
	input  wire [15:0]            reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [15:0]            reg_rdata,
	input  wire                   run_start,
	input  wire                   running,
	input  wire                   exec_valid,
	input  wire                   exec_first,
	input  wire                   exec_break,
	input  wire [`TTC_AW-1:0]     exec_addr,
	input  wire [7:0]             probe_pins,
	input  wire                   ram_wr,
	input  wire [`TTC_RAW-1:0]    ram_waddr,
	input  wire [3:0]             ram_wdata,
	output reg                    trace_we,
	output reg  [`TTC_TPW-1:0]    trace_addr,
	output reg  [`TTC_AW-1:0]     trace_loc,
	output wire                   trace_overflow,
	output wire                   trace_active
);

	localparam DEPTH = 1 << `TTC_AW;

	// Configuration registers
	reg  [2:0]            mode_ff;
	reg                   src_ram_ff;
	reg                   ramsel_ff;
	reg  [1:0]            st_kind_ff;
	reg  [`TTC_AW-1:0]    st_lo_ff;
	reg  [`TTC_AW-1:0]    st_hi_ff;
	reg  [1:0]            sp_kind_ff;
	reg  [`TTC_AW-1:0]    sp_lo_ff;
	reg  [`TTC_AW-1:0]    sp_hi_ff;
	// Pending (staged) window settings
	reg  [1:0]            pst_kind_ff;
	reg  [`TTC_AW-1:0]    pst_lo_ff;
	reg  [`TTC_AW-1:0]    pst_hi_ff;
	reg  [1:0]            psp_kind_ff;
	reg  [`TTC_AW-1:0]    psp_lo_ff;
	reg  [`TTC_AW-1:0]    psp_hi_ff;
	reg                   pst_got_ff;
	reg                   psp_got_ff;
	reg  [7:0]            mval_ff;
	reg  [7:0]            mmsk_ff;
	reg  [`TTC_RAW-1:0]   ramadr_ff;
	reg  [3:0]            ramdat_ff;
	reg  [7:0]            objsel_ff;
	reg  [`TTC_AW-1:0]    enadr_ff;
	reg                   active_ff;
	reg                   ovf_ff;
	reg  [`TTC_TPW-1:0]   tptr_ff;

	// Per-address trace enable bits
	reg                   en_mem [0:DEPTH-1];
	reg                   en_rd_ff;

	wire                  wr_mode  = reg_wr && reg_addr == `TTC_REG_MODE;
	wire                  wr_st    = reg_wr && reg_addr == `TTC_REG_START;
	wire                  wr_sthi  = reg_wr && reg_addr == `TTC_REG_START_HI;
	wire                  wr_sp    = reg_wr && reg_addr == `TTC_REG_STOP;
	wire                  wr_sphi  = reg_wr && reg_addr == `TTC_REG_STOP_HI;
	wire                  wr_obj   = reg_wr && reg_addr == `TTC_REG_OBJSEL;
	wire                  wr_tptr  = reg_wr && reg_addr == `TTC_REG_TPTR;
	wire                  wr_enbit = reg_wr && reg_addr == `TTC_REG_ENBIT;

	// Selected match source with mask width chosen by source
	wire [7:0]            src_val  = src_ram_ff ? {4'h0, ramdat_ff}
	                                            : probe_pins;
	wire [7:0]            msk_eff  = mmsk_ff & (src_ram_ff ? `TTC_RAM_MASK
	                                            : `TTC_PRB_MASK);
	wire [7:0]            cmp_bits = src_ram_ff ? `TTC_RAM_MASK
	                                            : `TTC_PRB_MASK;
	wire                  dmatch   = (((src_val ^ mval_ff) & ~msk_eff)
	                                  & cmp_bits) == 8'h00;

	// Address condition hits
	wire                  st_hit = (st_kind_ff == `TTC_K_ADDR &&
	                                exec_addr == st_lo_ff) ||
	                               (st_kind_ff == `TTC_K_RANGE &&
	                                exec_addr >= st_lo_ff &&
	                                exec_addr <= st_hi_ff);
	wire                  sp_hit = (sp_kind_ff == `TTC_K_ADDR &&
	                                exec_addr == sp_lo_ff) ||
	                               (sp_kind_ff == `TTC_K_RANGE &&
	                                exec_addr >= sp_lo_ff &&
	                                exec_addr <= sp_hi_ff);

	wire                  ex       = running && exec_valid;
	wire                  en_bit   = en_mem[exec_addr];

	reg                   nxt_active;
	reg                   rec;

	// Capture decision per executed cycle
	always @* begin
		nxt_active = active_ff;
		rec        = 1'b0;
		case (mode_ff)
			`TTC_M_FREE: begin
				rec = ex;
			end
			`TTC_M_ENBIT: begin
				rec = ex && exec_first && en_bit;
			end
			`TTC_M_OFF: begin
				rec = 1'b0;
			end
			`TTC_M_WINDOW: begin
				if (run_start)
					nxt_active = (st_kind_ff == `TTC_K_RUN);
				if (ex) begin
					if ((nxt_active || st_hit) && sp_hit) begin
						nxt_active = 1'b0;
					end else if (nxt_active || st_hit) begin
						nxt_active = 1'b1;
						rec = !exec_break ||
						      sp_kind_ff == `TTC_K_RUN;
					end
				end
			end
			`TTC_M_AFTER: begin
				if (run_start)
					nxt_active = 1'b0;
				if (ex && dmatch)
					nxt_active = 1'b1;
				rec = ex && nxt_active;
			end
			`TTC_M_BEFORE: begin
				if (run_start)
					nxt_active = 1'b1;
				if (ex && dmatch)
					nxt_active = 1'b0;
				rec = ex && nxt_active;
			end
			default: begin
				rec = 1'b0;
			end
		endcase
	end

	// Enable bit memory write and host read port
	always @(posedge mclk) begin
		if (wr_enbit)
			en_mem[enadr_ff] <= reg_wdata[0];
		en_rd_ff <= en_mem[enadr_ff];
	end

	// Mirror data memory location used as match source
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ramdat_ff <= 4'h0;
		end else if (ram_wr && (!ramsel_ff || ram_waddr == ramadr_ff)) begin
			ramdat_ff <= ram_wdata;
		end
	end

	// Host configuration and staged window update
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff     <= `TTC_MODE_RST;
			src_ram_ff  <= 1'b0;
			ramsel_ff   <= 1'b0;
			st_kind_ff  <= `TTC_K_RUN;
			st_lo_ff    <= {`TTC_AW{1'b0}};
			st_hi_ff    <= {`TTC_AW{1'b0}};
			sp_kind_ff  <= `TTC_K_RUN;
			sp_lo_ff    <= {`TTC_AW{1'b0}};
			sp_hi_ff    <= {`TTC_AW{1'b0}};
			pst_kind_ff <= `TTC_K_KEEP;
			pst_lo_ff   <= {`TTC_AW{1'b0}};
			pst_hi_ff   <= {`TTC_AW{1'b0}};
			psp_kind_ff <= `TTC_K_KEEP;
			psp_lo_ff   <= {`TTC_AW{1'b0}};
			psp_hi_ff   <= {`TTC_AW{1'b0}};
			pst_got_ff  <= 1'b0;
			psp_got_ff  <= 1'b0;
			mval_ff     <= 8'h00;
			mmsk_ff     <= 8'h00;
			ramadr_ff   <= {`TTC_RAW{1'b0}};
			objsel_ff   <= 8'h00;
			enadr_ff    <= {`TTC_AW{1'b0}};
		end else begin
			if (wr_mode) begin
				mode_ff    <= reg_wdata[`TTC_MODE_LSB+2:`TTC_MODE_LSB];
				src_ram_ff <= reg_wdata[`TTC_SRC_BIT];
				ramsel_ff  <= reg_wdata[`TTC_RAMSEL_BIT];
			end
			if (wr_st) begin
				pst_kind_ff <= reg_wdata[13:12];
				pst_lo_ff   <= reg_wdata[`TTC_AW-1:0];
				pst_got_ff  <= 1'b1;
			end
			if (wr_sthi)
				pst_hi_ff <= reg_wdata[`TTC_AW-1:0];
			if (wr_sp) begin
				psp_kind_ff <= reg_wdata[13:12];
				psp_lo_ff   <= reg_wdata[`TTC_AW-1:0];
				psp_got_ff  <= 1'b1;
			end
			if (wr_sphi)
				psp_hi_ff <= reg_wdata[`TTC_AW-1:0];
			// Commit both conditions at once
			if (pst_got_ff && psp_got_ff) begin
				pst_got_ff <= 1'b0;
				psp_got_ff <= 1'b0;
				if (pst_kind_ff != `TTC_K_KEEP) begin
					st_kind_ff <= pst_kind_ff;
					st_lo_ff   <= pst_lo_ff;
					st_hi_ff   <= pst_hi_ff;
				end
				if (psp_kind_ff != `TTC_K_KEEP) begin
					sp_kind_ff <= psp_kind_ff;
					sp_lo_ff   <= psp_lo_ff;
					sp_hi_ff   <= psp_hi_ff;
				end
			end
			if (reg_wr && reg_addr == `TTC_REG_MATCH) begin
				mval_ff <= reg_wdata[`TTC_MVAL_LSB+7:`TTC_MVAL_LSB];
				mmsk_ff <= reg_wdata[`TTC_MMSK_LSB+7:`TTC_MMSK_LSB];
			end
			if (reg_wr && reg_addr == `TTC_REG_RAMADR)
				ramadr_ff <= reg_wdata[`TTC_RAW-1:0];
			if (wr_obj)
				objsel_ff <= reg_wdata[7:0];
			if (reg_wr && reg_addr == `TTC_REG_ENADR)
				enadr_ff <= reg_wdata[`TTC_AW-1:0];
		end
	end

	// Trace state, pointer and trace memory write port
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			active_ff  <= 1'b0;
			tptr_ff    <= {`TTC_TPW{1'b0}};
			ovf_ff     <= 1'b0;
			trace_we   <= 1'b0;
			trace_addr <= {`TTC_TPW{1'b0}};
			trace_loc  <= {`TTC_AW{1'b0}};
		end else begin
			active_ff <= nxt_active;
			trace_we  <= rec;
			if (rec) begin
				trace_addr <= tptr_ff;
				trace_loc  <= exec_addr;
			end
			if (wr_obj || wr_tptr) begin
				tptr_ff <= {`TTC_TPW{1'b0}};
				ovf_ff  <= 1'b0;
			end else if (rec) begin
				tptr_ff <= tptr_ff + 1'b1;
				if (&tptr_ff)
					ovf_ff <= 1'b1;
			end
		end
	end

	assign trace_overflow = ovf_ff;
	assign trace_active   = active_ff;

	// Register read, data one cycle after the strobe
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`TTC_REG_MODE:   reg_rdata <= {10'h000, ramsel_ff,
				                               src_ram_ff, 1'b0, mode_ff};
				`TTC_REG_START:  reg_rdata <= {2'h0, st_kind_ff, st_lo_ff};
				`TTC_REG_START_HI: reg_rdata <= {4'h0, st_hi_ff};
				`TTC_REG_STOP:   reg_rdata <= {2'h0, sp_kind_ff, sp_lo_ff};
				`TTC_REG_STOP_HI: reg_rdata <= {4'h0, sp_hi_ff};
				`TTC_REG_MATCH:  reg_rdata <= {mmsk_ff, mval_ff};
				`TTC_REG_RAMADR: reg_rdata <= {8'h00, ramadr_ff};
				`TTC_REG_OBJSEL: reg_rdata <= {8'h00, objsel_ff};
				`TTC_REG_TPTR:   reg_rdata <= {6'h00, tptr_ff};
				`TTC_REG_ENBIT:  reg_rdata <= {15'h0000, en_rd_ff};
				`TTC_REG_ENADR:  reg_rdata <= {4'h0, enadr_ff};
				`TTC_REG_STATUS: reg_rdata <= {12'h000, pst_got_ff,
				                               psp_got_ff, active_ff, ovf_ff};
				default:         reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule // ttc_trace_trigger

// ---- sim/ttc_trace_trigger_asserts.sv ----
// Port checker for the trace trigger block
`timescale 1ns/10ps
`include "ttc_defines.vh"
module ttc_trace_trigger_asserts (
	input wire                  mclk,
	input wire                  rst_n,
	input wire [`TTC_REGAW-1:0] reg_addr,
	input wire [15:0]           reg_wdata,
	input wire                  reg_wr,
	input wire                  reg_rd,
	input wire [15:0]           reg_rdata,
	input wire                  running,
	input wire                  exec_valid,
	input wire                  exec_first,
	input wire [`TTC_AW-1:0]    exec_addr,
	input wire                  trace_we,
	input wire [`TTC_TPW-1:0]   trace_addr,
	input wire [`TTC_AW-1:0]    trace_loc,
	input wire                  trace_overflow
);
	reg [2:0] mode_ff;
	// Shadow of the capture mode, free-running from reset
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			mode_ff <= `TTC_MODE_RST;
		else if (reg_wr && reg_addr == `TTC_REG_MODE)
			mode_ff <= reg_wdata[2:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Entry timing, mode gating and pointer behaviour
	property p_cause; trace_we |-> $past(running && exec_valid);
	endproperty
	a_cause: assert property (p_cause) else $error("stray entry");
	property p_free; mode_ff == `TTC_M_FREE && running && exec_valid
		|=> trace_we && trace_loc == $past(exec_addr);
	endproperty
	a_free: assert property (p_free) else $error("free miss");
	property p_off; trace_we |-> $past(mode_ff) != `TTC_M_OFF;
	endproperty
	a_off: assert property (p_off) else $error("entry when off");
	property p_first; trace_we && $past(mode_ff) == `TTC_M_ENBIT
		|-> $past(exec_first);
	endproperty
	a_first: assert property (p_first) else $error("later byte");
	property p_step; !reg_wr ##1 (trace_we && !reg_wr) ##1 trace_we
		|-> trace_addr == $past(trace_addr) + 1'b1;
	endproperty
	a_step: assert property (p_step) else $error("pointer step");
	// Overflow rises together with the entry written at the last index
	property p_ovf; $rose(trace_overflow) |-> trace_we && &trace_addr;
	endproperty
	a_ovf: assert property (p_ovf) else $error("early overflow");
	property p_obj; reg_wr && reg_addr == `TTC_REG_OBJSEL
		|-> ##2 !trace_overflow;
	endproperty
	a_obj: assert property (p_obj) else $error("no clear");
	property p_rdata; !$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("stale read");
endmodule // ttc_trace_trigger_asserts
bind ttc_trace_trigger ttc_trace_trigger_asserts u_chk (.mclk(mclk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.running(running), .exec_valid(exec_valid), .exec_first(exec_first),
	.exec_addr(exec_addr), .trace_we(trace_we), .trace_addr(trace_addr),
	.trace_loc(trace_loc), .trace_overflow(trace_overflow));

// ---- sim/ttc_core_model.sv ----
// Behavioural emulated core feeding executed addresses
`timescale 1ns/10ps
`include "ttc_defines.vh"
module ttc_core_model (
	input  wire              mclk,
	output reg               run_start = 1'b0,
	output reg               running = 1'b0,
	output reg               exec_valid = 1'b0,
	output reg               exec_first = 1'b0,
	output reg               exec_break = 1'b0,
	output reg [`TTC_AW-1:0] exec_addr = 12'h000,
	output reg [7:0]         probe_pins = 8'h00
);
	// One executed byte per cycle during realtime emulation
	task exe(input [11:0] a, input f, input b, input [7:0] p);
		@(posedge mclk);
		exec_valid <= 1'b1;
		run_start <= 1'b0;
		exec_addr <= a;
		exec_first <= f;
		exec_break <= b;
		probe_pins <= p;
	endtask
	// Idle bus shows no stale address
	task idle;
		@(posedge mclk);
		exec_valid <= 1'b0;
		exec_addr <= ~exec_addr;
	endtask
	// Run command start
	task go;
		@(posedge mclk);
		exec_valid <= 1'b0;
		running <= 1'b1;
		run_start <= 1'b1;
	endtask
endmodule // ttc_core_model

// ---- sim/ttc_trace_trigger_tb.sv ----
// Self-checking bench for the trace trigger block
`timescale 1ns/10ps
`include "ttc_defines.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	n_mismatch++; $display("Error %s exp %0h got %0h", n, e, g); end end
module ttc_trace_trigger_tb;
	logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, d;
	wire  [15:0] reg_rdata;
	wire         run_start, running, exec_valid, exec_first, exec_break;
	wire         trace_we, trace_overflow, trace_active;
	wire  [11:0] exec_addr, trace_loc;
	wire  [9:0]  trace_addr;
	wire  [7:0]  probe_pins;
	int n_mismatch = 0, checks_done = 0, cyc = 0, i, e, em, m_ptr = 0;
	int m_ovf = 0, m_act = 0, m_mode = 0, m_srun = 1, m_cont = 1;
	int s_lo = -1, s_hi = -2, p_lo = -1, p_hi = -2, m_val = 0, m_msk = 0;
	int q[$];
	bit en[int];
	int unsigned rs = 57323;
	ttc_core_model core (.mclk(mclk), .run_start(run_start),
		.running(running), .exec_valid(exec_valid), .exec_first(exec_first),
		.exec_break(exec_break), .exec_addr(exec_addr),
		.probe_pins(probe_pins));
	ttc_trace_trigger DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .run_start(run_start), .running(running),
		.exec_valid(exec_valid), .exec_first(exec_first),
		.exec_break(exec_break), .exec_addr(exec_addr),
		.probe_pins(probe_pins), .ram_wr(1'b0), .ram_waddr(8'h00),
		.ram_wdata(4'h0), .trace_we(trace_we), .trace_addr(trace_addr),
		.trace_loc(trace_loc), .trace_overflow(trace_overflow),
		.trace_active(trace_active));
	function int rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task wr(input int a, input int v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a[3:0];
		reg_wdata <= v[15:0];
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input int a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a[3:0];
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task quiet;
		core.idle();
		repeat (2) @(posedge mclk);
		@(negedge mclk);
	endtask
	task setm(input int m);
		core.idle();
		wr(`TTC_REG_MODE, m);
		m_mode = m;
		m_act = 0;
	endtask
	task run;
		core.go();
		if (m_mode == 5 || (m_mode == 3 && m_srun)) m_act = 1;
	endtask
	task win(input int sk, slo, shi, pk, plo, phi);
		wr(`TTC_REG_START_HI, shi);
		wr(`TTC_REG_START, sk << 12 | slo);
		rd(`TTC_REG_STATUS);
		`CHK("pending", 8, d & 16'h000C)
		wr(`TTC_REG_STOP_HI, phi);
		wr(`TTC_REG_STOP, pk << 12 | plo);
		if (sk) s_lo = sk == 3 ? -1 : slo;
		if (sk) s_hi = sk == 3 ? -2 : sk == 2 ? shi : slo;
		if (sk) m_srun = sk == 3;
		if (pk) p_lo = pk == 3 ? -1 : plo;
		if (pk) p_hi = pk == 3 ? -2 : pk == 2 ? phi : plo;
		if (pk) m_cont = pk == 3;
		repeat (2) @(posedge mclk);
	endtask
	// Reference model of one executed address
	task ex(input int a, input int f, input int b, input int p);
		int hit, rec;
		hit = ((p ^ m_val) & ~m_msk & 'hFF) == 0;
		rec = m_mode == 0;
		if (m_mode == 1) rec = f && en[a];
		if (m_mode == 3 && a >= p_lo && a <= p_hi) m_act = 0;
		else if (m_mode == 3 && a >= s_lo && a <= s_hi) m_act = 1;
		if (m_mode == 3) rec = m_act && !(b && !m_cont);
		if (m_mode == 4) m_act |= hit;
		if (m_mode == 4) rec = m_act;
		if (m_mode == 5) rec = m_act && !hit;
		if (m_mode == 5 && hit) m_act = 0;
		if (rec) q.push_back(m_ptr << 12 | a);
		if (rec) m_ptr = (m_ptr + 1) % 1024;
		if (rec && m_ptr == 0) m_ovf = 1;
		core.exe(a[11:0], f[0], b[0], p[7:0]);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial forever #50 mclk = ~mclk;
	// Entry monitor and run limit
	always @(negedge mclk) if (trace_we === 1'b1) begin
		em = q.size() ? q.pop_front() : -1;
		`CHK("entry", em, {trace_addr, trace_loc})
	end
	always @(posedge mclk) if (++cyc == 12000) begin
		n_mismatch++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		run();
		for (i = 0; i < 1030; i++) ex(rnd() & 'hFFF, rnd() & 1, 0, 0);
		quiet();
		`CHK("ovf", m_ovf, trace_overflow)
		rd(`TTC_REG_TPTR);
		`CHK("tptr", m_ptr, d)
		wr(`TTC_REG_OBJSEL, 1);
		m_ptr = 0;
		ex('h3A5, 1, 0, 0);
		quiet();
		`CHK("ovf clr", 0, trace_overflow)
		$display("test free done");
		setm(`TTC_M_ENBIT);
		for (i = 'h20; i < 'h28; i++) begin
			en[i] = rnd() & 1;
			wr(`TTC_REG_ENADR, i);
			wr(`TTC_REG_ENBIT, en[i]);
		end
		for (i = 'h20; i < 'h28; i++) begin
			wr(`TTC_REG_ENADR, i);
			@(posedge mclk);
			rd(`TTC_REG_ENBIT);
			`CHK("enbit", en[i], d[0])
		end
		for (i = 0; i < 32; i++) ex('h20 + i % 8, rnd() & 1, 0, 0);
		setm(`TTC_M_OFF);
		for (i = 0; i < 8; i++) ex(rnd() & 'hFFF, 1, 0, 0);
		$display("test enable and off done");
		m_val = 'h05;
		m_msk = 'hF0;
		wr(`TTC_REG_MATCH, 16'hF005);
		for (e = 4; e < 6; e++) begin
			setm(e);
			run();
			for (i = 0; i < 24; i++) ex('h100 + i, 1, 0, rnd() & 'hFF);
		end
		$display("test match done");
		setm(`TTC_M_WINDOW);
		win(`TTC_K_ADDR, 'h104, 0, `TTC_K_ADDR, 'h10C, 0);
		run();
		for (e = 0; e < 3; e++) begin
			for (i = 0; i < 16; i++) ex('h100 + i, 1, 0, 0);
			quiet();
			if (e == 0) win(0, 0, 0, 0, 0, 0);
			if (e == 1) win(2, 'h106, 'h108, 2, 'h10A, 'h10B);
		end
		win(`TTC_K_RUN, 0, 0, `TTC_K_RUN, 0, 0);
		run();
		for (i = 0; i < 16; i++) ex('h200 + i, 1, rnd() & 1, 0);
		quiet();
		`CHK("left", 0, q.size())
		`CHK("active", m_act, trace_active)
		$display("test window done");
		conclude();
	end
endmodule // ttc_trace_trigger_tb
